// ### xvcr_regs.sv
// module: volatile configuration register bank with wishbone slave and link-side settings
module xvcr_regs
  import xvcr_pkg::*;
#(
  parameter int LANES = 8,
  parameter logic SMALL_PKG = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [XVCR_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic lat_start_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_opcode_i,
  input wire logic xip_confirm_i,
  input wire logic drive_i,
  output logic [7:0] io_oe_n_o,
  output logic [1:0] io_width_o,
  output logic ddr_o,
  output logic strobe_en_o,
  output logic wp_func_o,
  output logic reset_func_o,
  output logic [4:0] read_dummy_o,
  output logic data_phase_o,
  output logic [1:0] imp_sel_o,
  output logic [3:0] strobe_taps_o,
  output logic [2:0] reg_addr_bytes_o,
  output logic xip_continue_o,
  output logic [2:0] rd_wrap_o,
  output logic [2:0] wr_wrap_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] io_mode;
    logic [7:0] latency;
    logic [7:0] imped;
    logic [3:0] strobe_dly;
    logic [7:0] addr_mode;
    logic [7:0] execute_in_place;
    logic [7:0] wrap;
    logic mem_mode;
    logic ack;
    logic [31:0] rdata;
    xvcr_mode_t act_mode;
    logic [4:0] act_dummy;
    logic [1:0] act_imp;
    logic [3:0] act_taps;
    logic act_addr4;
    logic act_xip_en;
    logic [2:0] act_rd_wrap;
    logic [2:0] act_wr_wrap;
    logic in_frame;
    logic counting;
    logic [4:0] cnt;
    logic data_phase;
    logic xip_cont;
  } xvcr_state_t;

  xvcr_state_t s_q, s_d;

  logic sck_rise;
  logic cs_n_sync;
  logic cs_fall;
  logic cs_rise;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  xvcr_pin_sync #(.RST_VAL(1'b0)) u_sck_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(sck_i),
    .level_o(),
    .rise_o(sck_rise),
    .fall_o()
  );

  xvcr_pin_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(cs_n_i),
    .level_o(cs_n_sync),
    .rise_o(cs_rise),
    .fall_o(cs_fall)
  );

  // ----------------------------------------------------------------
  // live decode of the stored codes
  // ----------------------------------------------------------------
  xvcr_mode_t live_mode;
  logic [4:0] live_dummy;
  logic [1:0] live_imp;
  logic [2:0] live_rd_wrap;
  logic [3:0] req_idx;
  logic req_ok;
  logic req;

  always_comb begin
    live_mode = xvcr_decode_mode(s_q.io_mode);
    // an eight-lane code on a four-lane part is not honoured
    if (LANES < 8 && live_mode.width == XVCR_W_OCTAL) begin
      live_mode = XVCR_MODE_DFLT;
    end
    if (s_q.latency[7:5] == 3'b000 && s_q.latency[4:0] >= XVCR_DUMMY_MIN && s_q.latency[4:0] <= XVCR_DUMMY_MAX) begin
      live_dummy = s_q.latency[4:0];
    end else begin
      live_dummy = XVCR_DUMMY_DFLT;
    end
    case (s_q.imped)
      8'hfe: live_imp = XVCR_IMP_35;
      8'hfd: live_imp = XVCR_IMP_25;
      8'hfc: live_imp = XVCR_IMP_18;
      default: live_imp = XVCR_IMP_50;
    endcase
    case (s_q.wrap)
      8'hfe: live_rd_wrap = XVCR_WRAP_64;
      8'hfd: live_rd_wrap = XVCR_WRAP_32;
      8'hfc: live_rd_wrap = XVCR_WRAP_16;
      default: live_rd_wrap = XVCR_WRAP_CONT;
    endcase
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign req_idx = wb_adr_i[5:2];
  assign req_ok = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i[XVCR_ADR_W-1:6] == '0) && (req_idx <= XVCR_IDX_MEM_MODE);
  assign req = wb_cyc_i & wb_stb_i;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = req & ~s_q.ack;
    // writes land on the edge where the master sees ack
    if (req && s_q.ack && wb_we_i && wb_sel_i[0] && req_ok) begin
      case (req_idx)
        XVCR_IDX_IO_MODE: s_d.io_mode = wb_dat_i[7:0];
        XVCR_IDX_LATENCY: s_d.latency = wb_dat_i[7:0];
        XVCR_IDX_IMPED: s_d.imped = wb_dat_i[7:0];
        XVCR_IDX_STROBE_DLY: s_d.strobe_dly = wb_dat_i[3:0];
        XVCR_IDX_ADDR_MODE: s_d.addr_mode = wb_dat_i[7:0];
        XVCR_IDX_XIP: s_d.execute_in_place = wb_dat_i[7:0];
        XVCR_IDX_WRAP: s_d.wrap = wb_dat_i[7:0];
        XVCR_IDX_MEM_MODE: s_d.mem_mode = wb_dat_i[0];
        default: s_d.mem_mode = s_q.mem_mode;
      endcase
    end
    s_d.rdata = '0;
    if (req && !s_q.ack && req_ok) begin
      case (req_idx)
        XVCR_IDX_IO_MODE: s_d.rdata[7:0] = s_q.io_mode;
        XVCR_IDX_LATENCY: s_d.rdata[7:0] = s_q.latency;
        XVCR_IDX_IMPED: s_d.rdata[7:0] = s_q.imped;
        XVCR_IDX_STROBE_DLY: s_d.rdata[3:0] = s_q.strobe_dly;
        XVCR_IDX_ADDR_MODE: s_d.rdata[7:0] = s_q.addr_mode;
        XVCR_IDX_XIP: s_d.rdata[7:0] = s_q.execute_in_place;
        XVCR_IDX_WRAP: s_d.rdata[7:0] = s_q.wrap;
        XVCR_IDX_MEM_MODE: s_d.rdata[0] = s_q.mem_mode;
        default: s_d.rdata = '0;
      endcase
    end else if (s_q.ack) begin
      s_d.rdata = s_q.rdata;
    end

    // frame tracking: settings freeze for the length of a frame
    if (cs_fall) begin
      s_d.in_frame = 1'b1;
    end else if (cs_rise || cs_n_sync) begin
      s_d.in_frame = 1'b0;
    end
    if (!s_q.in_frame) begin
      s_d.act_mode = live_mode;
      s_d.act_dummy = live_dummy;
      s_d.act_imp = live_imp;
      s_d.act_taps = 4'hf - s_q.strobe_dly;
      s_d.act_addr4 = (s_q.addr_mode == XVCR_ADDR_4BYTE);
      s_d.act_xip_en = (s_q.execute_in_place == XVCR_XIP_ENABLE);
      s_d.act_rd_wrap = live_rd_wrap;
      s_d.act_wr_wrap = s_q.mem_mode ? XVCR_WRAP_PAGE : XVCR_WRAP_CONT;
    end

    // latency count in rising serial clock edges after the address phase
    if (!s_q.in_frame || cs_rise) begin
      s_d.counting = 1'b0;
      s_d.cnt = '0;
      s_d.data_phase = 1'b0;
    end else if (lat_start_i) begin
      s_d.counting = 1'b1;
      s_d.cnt = '0;
      s_d.data_phase = 1'b0;
    end else if (s_q.counting && sck_rise) begin
      if (s_q.cnt + 5'd1 >= s_q.act_dummy) begin
        s_d.counting = 1'b0;
        s_d.data_phase = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 5'd1;
      end
    end

    if (cmd_valid_i) begin
      s_d.xip_cont = s_q.act_xip_en && (cmd_opcode_i == XVCR_FAST_READ_OP) && !xip_confirm_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.io_mode <= XVCR_RST_IO_MODE;
      s_q.latency <= XVCR_RST_LATENCY;
      s_q.imped <= XVCR_RST_IMPED;
      s_q.strobe_dly <= XVCR_RST_STROBE_DLY;
      s_q.addr_mode <= XVCR_RST_ADDR_MODE;
      s_q.execute_in_place <= XVCR_RST_XIP;
      s_q.wrap <= XVCR_RST_WRAP;
      s_q.mem_mode <= XVCR_RST_MEM_MODE;
      s_q.act_mode <= XVCR_MODE_DFLT;
      s_q.act_dummy <= XVCR_DUMMY_DFLT;
      s_q.act_wr_wrap <= XVCR_WRAP_PAGE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [7:0] lanes_used;
  logic dual_mode;

  assign lanes_used = xvcr_lanes_of(s_q.act_mode.width);
  assign dual_mode = (s_q.act_mode.width == XVCR_W_DUAL);
  // enables are active low: only used lanes drive, and only while data goes out
  assign io_oe_n_o = ~(lanes_used & {8{drive_i}});
  assign wp_func_o = dual_mode && (LANES == 8 || SMALL_PKG);
  assign reset_func_o = dual_mode && (LANES == 4) && SMALL_PKG;
  assign io_width_o = s_q.act_mode.width;
  assign ddr_o = s_q.act_mode.ddr;
  assign strobe_en_o = s_q.act_mode.strobe;
  assign read_dummy_o = s_q.act_dummy;
  assign data_phase_o = s_q.data_phase;
  assign imp_sel_o = s_q.act_imp;
  assign strobe_taps_o = s_q.act_taps;
  assign reg_addr_bytes_o = s_q.act_addr4 ? 3'd4 : 3'd3;
  assign xip_continue_o = s_q.xip_cont;
  assign rd_wrap_o = s_q.act_rd_wrap;
  assign wr_wrap_o = s_q.act_wr_wrap;
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.ack ? s_q.rdata : 32'h0000_0000;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");

  a_xip_only_fetch: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_opcode_i != XVCR_FAST_READ_OP |=> !xip_continue_o) else $error("xip kept after other read");

  a_wrap_write_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.in_frame && !s_q.mem_mode |=> wr_wrap_o == XVCR_WRAP_CONT) else $error("write wrap wrong");

  a_addr_bytes_four: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.in_frame && s_q.addr_mode == XVCR_ADDR_4BYTE |=> reg_addr_bytes_o == 3'd4) else $error("address length wrong");

  a_quad_upper_float: assert property (@(posedge clk_i) disable iff (rst_i)
    io_width_o == XVCR_W_QUAD |-> io_oe_n_o[7:4] == 4'hf) else $error("upper lanes driven in quad");

  a_dual_lane_use: assert property (@(posedge clk_i) disable iff (rst_i)
    io_width_o == XVCR_W_DUAL && LANES == 8 |-> wp_func_o && io_oe_n_o[7:2] == 6'h3f) else $error("dual lanes wrong");

  a_single_lane_one: assert property (@(posedge clk_i) disable iff (rst_i)
    io_width_o == XVCR_W_SINGLE |-> io_oe_n_o[1]) else $error("lane one driven in single mode");

  a_strobe_no_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.in_frame && s_q.strobe_dly == 4'hf |=> strobe_taps_o == 4'h0) else $error("strobe delay at default");

  a_dummy_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
    read_dummy_o >= XVCR_DUMMY_MIN && read_dummy_o <= XVCR_DUMMY_MAX) else $error("dummy count out of range");

  a_imp_default: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.in_frame && s_q.imped == 8'hff |=> imp_sel_o == XVCR_IMP_50) else $error("impedance default wrong");

  a_frame_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.in_frame && $past(s_q.in_frame) |-> $stable(read_dummy_o) && $stable(io_width_o)) else $error("setting changed mid frame");

  a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack after request");

  a_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");

  a_xip_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_valid_i && !s_q.act_xip_en |=> !xip_continue_o) else $error("xip kept while disabled");

  a_rd_wrap_cont: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.in_frame && s_q.wrap == 8'hff |=> rd_wrap_o == XVCR_WRAP_CONT) else $error("read wrap wrong");

  a_addr_bytes_three: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.in_frame && s_q.addr_mode != XVCR_ADDR_4BYTE |=> reg_addr_bytes_o == 3'd3) else $error("address length wrong");

  a_small_dual_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    io_width_o == XVCR_W_DUAL && LANES == 4 && SMALL_PKG |-> wp_func_o && reset_func_o) else $error("dual pins wrong");

  a_octal_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    LANES < 8 |-> io_width_o != XVCR_W_OCTAL) else $error("octal width on four-lane part");

  a_strobe_max_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.in_frame && s_q.strobe_dly == 4'h0 |=> strobe_taps_o == 4'hf) else $error("strobe delay not at maximum");

  a_mode_default: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.in_frame && s_q.io_mode == 8'hff |=> io_width_o == XVCR_W_SINGLE && !ddr_o && strobe_en_o) else $error("mode default wrong");

  a_data_phase_end: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_rise |=> !data_phase_o) else $error("data phase kept after frame");

endmodule : xvcr_regs

// ### xvcr_pkg.sv
// package: register map, field codes and decode helpers of the volatile configuration bank
package xvcr_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] XVCR_IDX_IO_MODE = 4'h0;
  localparam logic [3:0] XVCR_IDX_LATENCY = 4'h1;
  localparam logic [3:0] XVCR_IDX_SPARE2 = 4'h2;
  localparam logic [3:0] XVCR_IDX_IMPED = 4'h3;
  localparam logic [3:0] XVCR_IDX_STROBE_DLY = 4'h4;
  localparam logic [3:0] XVCR_IDX_ADDR_MODE = 4'h5;
  localparam logic [3:0] XVCR_IDX_XIP = 4'h6;
  localparam logic [3:0] XVCR_IDX_WRAP = 4'h7;
  localparam logic [3:0] XVCR_IDX_MEM_MODE = 4'h8;
  localparam int XVCR_ADR_W = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] XVCR_RST_IO_MODE = 8'hff;
  localparam logic [7:0] XVCR_RST_LATENCY = 8'h10;
  localparam logic [7:0] XVCR_RST_IMPED = 8'hff;
  localparam logic [3:0] XVCR_RST_STROBE_DLY = 4'hf;
  localparam logic [7:0] XVCR_RST_ADDR_MODE = 8'hff;
  localparam logic [7:0] XVCR_RST_XIP = 8'hff;
  localparam logic [7:0] XVCR_RST_WRAP = 8'hff;
  localparam logic XVCR_RST_MEM_MODE = 1'b1;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [7:0] XVCR_XIP_ENABLE = 8'hfe;
  localparam logic [7:0] XVCR_ADDR_4BYTE = 8'hfe;
  localparam logic [7:0] XVCR_FAST_READ_OP = 8'h0b;
  localparam logic [4:0] XVCR_DUMMY_MIN = 5'h01;
  localparam logic [4:0] XVCR_DUMMY_MAX = 5'h1e;
  localparam logic [4:0] XVCR_DUMMY_DFLT = 5'h10;
  localparam int XVCR_STROBE_STEP_PS = 100;

  typedef enum logic [1:0] {
    XVCR_W_SINGLE = 2'b00,
    XVCR_W_DUAL = 2'b01,
    XVCR_W_QUAD = 2'b10,
    XVCR_W_OCTAL = 2'b11
  } xvcr_width_t;

  typedef enum logic [1:0] {
    XVCR_IMP_50 = 2'b00,
    XVCR_IMP_35 = 2'b01,
    XVCR_IMP_25 = 2'b10,
    XVCR_IMP_18 = 2'b11
  } xvcr_imp_t;

  typedef enum logic [2:0] {
    XVCR_WRAP_CONT = 3'b000,
    XVCR_WRAP_64 = 3'b001,
    XVCR_WRAP_32 = 3'b010,
    XVCR_WRAP_16 = 3'b011,
    XVCR_WRAP_PAGE = 3'b100
  } xvcr_wrap_t;

  typedef struct packed {
    xvcr_width_t width;
    logic ddr;
    logic strobe;
  } xvcr_mode_t;

  localparam xvcr_mode_t XVCR_MODE_DFLT = '{XVCR_W_SINGLE, 1'b0, 1'b1};

  // unlisted codes fall back to single lane with strobe
  function automatic xvcr_mode_t xvcr_decode_mode(input logic [7:0] code);
    case (code)
      8'hff: xvcr_decode_mode = '{XVCR_W_SINGLE, 1'b0, 1'b1};
      8'hdf: xvcr_decode_mode = '{XVCR_W_SINGLE, 1'b0, 1'b0};
      8'hfd: xvcr_decode_mode = '{XVCR_W_DUAL, 1'b0, 1'b1};
      8'hdd: xvcr_decode_mode = '{XVCR_W_DUAL, 1'b0, 1'b0};
      8'hfb: xvcr_decode_mode = '{XVCR_W_QUAD, 1'b0, 1'b1};
      8'hdb: xvcr_decode_mode = '{XVCR_W_QUAD, 1'b0, 1'b0};
      8'heb: xvcr_decode_mode = '{XVCR_W_QUAD, 1'b1, 1'b1};
      8'hcb: xvcr_decode_mode = '{XVCR_W_QUAD, 1'b1, 1'b0};
      8'hc7: xvcr_decode_mode = '{XVCR_W_OCTAL, 1'b1, 1'b1};
      8'hb7: xvcr_decode_mode = '{XVCR_W_OCTAL, 1'b0, 1'b1};
      8'h97: xvcr_decode_mode = '{XVCR_W_OCTAL, 1'b0, 1'b0};
      default: xvcr_decode_mode = XVCR_MODE_DFLT;
    endcase
  endfunction : xvcr_decode_mode

  // lanes that carry data in each width; single lane uses lane zero only
  function automatic logic [7:0] xvcr_lanes_of(input xvcr_width_t w);
    case (w)
      XVCR_W_SINGLE: xvcr_lanes_of = 8'h01;
      XVCR_W_DUAL: xvcr_lanes_of = 8'h03;
      XVCR_W_QUAD: xvcr_lanes_of = 8'h0f;
      XVCR_W_OCTAL: xvcr_lanes_of = 8'hff;
      default: xvcr_lanes_of = 8'h01;
    endcase
  endfunction : xvcr_lanes_of

endpackage : xvcr_pkg

// ### xvcr_pin_sync.sv
// module: two-stage pin synchroniser with edge pulses
module xvcr_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } xvcr_sync_state_t;

  xvcr_sync_state_t s_q, s_d;

  always_comb begin
    s_d.meta = async_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{RST_VAL, RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  // edges come from the second and third stages, never the first
  assign level_o = s_q.sync;
  assign rise_o = s_q.sync & ~s_q.prev;
  assign fall_o = ~s_q.sync & s_q.prev;

endmodule : xvcr_pin_sync

// ### xvcr_host_model.sv
// host side of the serial link: chip select framing and serial clock
module xvcr_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic [7:0] rises_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    rises_o = 8'h00;
  end

  // ----------------------------------------------------------------
  // one frame
  // ----------------------------------------------------------------
  // clock stands low outside frames; odd lead-in keeps it out of phase
  task automatic run_frame(input int n);
    rises_o = 8'h00;
    // step off the bench clock edge before the frame opens
    #7;
    cs_n_o = 1'b0;
    #1037;
    repeat (n) begin
      sck_o = 1'b1;
      rises_o = rises_o + 8'h01;
      #200;
      sck_o = 1'b0;
      #200;
    end
    #600;
    cs_n_o = 1'b1;
  endtask : run_frame
endmodule : xvcr_host_model

// ### xvcr_regs_tb_top.sv
// testbench: register bank over wishbone, link frames from the host model
module xvcr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic lat_start_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_opcode_i = 8'h00;
  logic xip_confirm_i = 1'b1;
  logic drive_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, sck_i, cs_n_i, ddr_o, strobe_en_o, wp_func_o, reset_func_o;
  logic data_phase_o, xip_continue_o;
  logic [7:0] io_oe_n_o, rises;
  logic [1:0] io_width_o, imp_sel_o;
  logic [4:0] read_dummy_o;
  logic [3:0] strobe_taps_o;
  logic [2:0] reg_addr_bytes_o, rd_wrap_o, wr_wrap_o;
  int failures = 0;
  int num_checks = 0;
  logic [7:0] rd_q[$];
  // {index, code, expected view}; eight-lane build, so octal codes are legal
  logic [19:0] tab[$] = {20'h0ff01, 20'h0df00, 20'h0fd05, 20'h0dd04, 20'h0fb09, 20'h0db08,
    20'h0eb0b, 20'h0cb0a, 20'h0c70f, 20'h0b70d, 20'h0970c, 20'h05a01, 20'h10101, 20'h11e1e,
    20'h11010, 20'h10010, 20'h11f10, 20'h1ff10, 20'h10f0f, 20'h3ff00, 20'h3fe01, 20'h3fd02,
    20'h3fc03, 20'h30000, 20'h4ff00, 20'h4f00f, 20'h4f708, 20'h5fe04, 20'h5ff03, 20'h50003,
    20'h7ff20, 20'h7fe21, 20'h7fd22, 20'h7fc23, 20'h70020, 20'h80000, 20'h80120, 20'h6fe00};
  // {index, read value, view} straight after reset
  logic [19:0] rtab[$] = {20'h0ff01, 20'h11010, 20'h20000, 20'h3ff00, 20'h40f00, 20'h5ff03,
    20'h6ff00, 20'h7ff20, 20'h80120};

  always #25 clk_i = ~clk_i;

  xvcr_regs #(.LANES(8), .SMALL_PKG(1'b0)) i_xvcr_regs (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sck_i, .cs_n_i,
    .lat_start_i, .cmd_valid_i, .cmd_opcode_i, .xip_confirm_i, .drive_i, .io_oe_n_o,
    .io_width_o, .ddr_o, .strobe_en_o, .wp_func_o, .reset_func_o, .read_dummy_o,
    .data_phase_o, .imp_sel_o, .strobe_taps_o, .reg_addr_bytes_o, .xip_continue_o,
    .rd_wrap_o, .wr_wrap_o);

  xvcr_host_model i_xvcr_host_model (.sck_o(sck_i), .cs_n_o(cs_n_i), .rises_o(rises));

  // ----------------------------------------------------------------
  // reporting and compares
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    failures++;
    $display("Error %0t: %s", $time, m);
  endtask : fail

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail($sformatf("%s got %h want %h", m, got, exp));
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  // entered right after a rising edge; holds the request until ack is seen
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    for (k = 0; k < 16; k++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) begin
        break;
      end
    end
    if (k == 16) begin
      fail("no bus answer");
      tally_and_finish();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    wb(a, 1'b0, 8'h00);
  endtask : rd

  function automatic logic [7:0] view(input logic [3:0] i);
    case (i)
      4'h0: view = {4'h0, io_width_o, ddr_o, strobe_en_o};
      4'h1: view = {3'h0, read_dummy_o};
      4'h3: view = {6'h0, imp_sel_o};
      4'h4: view = {4'h0, strobe_taps_o};
      4'h5: view = {5'h0, reg_addr_bytes_o};
      4'h6: view = {7'h0, xip_continue_o};
      4'h7, 4'h8: view = {2'h0, wr_wrap_o, rd_wrap_o};
      default: view = 8'h00;
    endcase
  endfunction : view

  task automatic apply(input logic [3:0] i, input logic [7:0] c, input logic [7:0] e);
    logic [7:0] rb;
    rb = (i == 4'h4) ? (c & 8'h0f) : ((i == 4'h8) ? (c & 8'h01) : c);
    wb({2'b00, i, 2'b00}, 1'b1, c);
    repeat (3) @(posedge clk_i);
    chk(view(i), e, "setting");
    rd({2'b00, i, 2'b00}, rb);
  endtask : apply

  task automatic cmd(input logic [7:0] op, input logic cf, input logic e);
    cmd_valid_i <= 1'b1;
    cmd_opcode_i <= op;
    xip_confirm_i <= cf;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({7'h0, xip_continue_o}, {7'h0, e}, "continue");
  endtask : cmd

  // n > 0 waits for that many serial clock rises, n == 0 for the frame end
  task automatic wait_host(input int n);
    int k;
    for (k = 0; k < 400; k++) begin
      @(posedge clk_i);
      if ((n > 0 && rises >= n) || (n == 0 && cs_n_i === 1'b1)) begin
        break;
      end
    end
    if (k == 400) begin
      fail("host wait");
      tally_and_finish();
    end
    repeat (5) @(posedge clk_i);
  endtask : wait_host

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rd_q.size() == 0) begin
        fail("read with no note");
      end else begin
        chk(wb_dat_o[7:0], rd_q.pop_front(), "read back");
      end
    end
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    fail("run too long");
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] c;
    void'($urandom(32'h46532de0));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rtab[j]) begin
      rd({2'b00, rtab[j][19:16], 2'b00}, rtab[j][15:8]);
      chk(view(rtab[j][19:16]), rtab[j][7:0], "reset view");
    end
    chk(io_oe_n_o, 8'hff, "idle lanes");
    rd(8'h24, 8'h00);
    rd(8'hc0, 8'h00);
    rd(8'h01, 8'h00);
    wb(8'h08, 1'b1, 8'h5a);
    rd(8'h08, 8'h00);
    drive_i <= 1'b1;
    foreach (tab[j]) begin
      apply(tab[j][19:16], tab[j][15:8], tab[j][7:0]);
      if (tab[j][19:16] == 4'h0) begin
        chk(io_oe_n_o, ~8'((1 << (1 << tab[j][3:2])) - 1), "lane enables");
        chk({6'h0, wp_func_o, reset_func_o}, {6'h0, tab[j][3:2] == 2'b01, 1'b0}, "pins");
      end
    end
    cmd(8'h0b, 1'b0, 1'b1);
    cmd(8'h03, 1'b0, 1'b0);
    cmd(8'h0b, 1'b0, 1'b1);
    cmd(8'h0b, 1'b1, 1'b0);
    apply(4'h6, 8'hff, 8'h00);
    cmd(8'h0b, 1'b0, 1'b0);
    repeat (4) begin
      c = 8'($urandom_range(30, 1));
      apply(4'h1, c, c);
      c = 8'($urandom());
      apply(4'h4, c, {4'h0, 4'hf - c[3:0]});
    end
    // latency count and frozen settings inside one frame
    apply(4'h1, 8'h03, 8'h03);
    fork
      i_xvcr_host_model.run_frame(3);
    join_none
    repeat (6) @(posedge clk_i);
    lat_start_i <= 1'b1;
    @(posedge clk_i);
    lat_start_i <= 1'b0;
    wb(8'h0c, 1'b1, 8'hfe);
    repeat (3) @(posedge clk_i);
    chk(view(4'h3), 8'h00, "frozen in frame");
    wait_host(2);
    chk({7'h0, data_phase_o}, 8'h00, "early data");
    wait_host(3);
    chk({7'h0, data_phase_o}, 8'h01, "data phase");
    wait_host(0);
    chk({7'h0, data_phase_o}, 8'h00, "frame end");
    chk(view(4'h3), 8'h01, "applied after frame");
    drive_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    if (rd_q.size() != 0) begin
      fail("reads left unanswered");
    end
    tally_and_finish();
  end
endmodule : xvcr_regs_tb_top
